/* afc_pkg.sv */
// constants, register map and pin carrier for the fifo host controller
package afc_pkg;
  // clock and pin timing
  localparam int CLK_NS       = 40;
  localparam int PULSE_NS     = 35;
  localparam int RECOVER_NS   = 10;
  localparam int RS_TO_R_NS   = 35;
  localparam int R_TO_LOAD_NS = 10;
  localparam int ACCESS_NS    = 35;
  localparam int SYNC_STAGES  = 2;
  // least times round up, never below one cycle
  localparam int PULSE_CYC   = (PULSE_NS + CLK_NS - 1) / CLK_NS > 0 ?
                               (PULSE_NS + CLK_NS - 1) / CLK_NS : 1;
  localparam int RECOVER_CYC = (RECOVER_NS + CLK_NS - 1) / CLK_NS > 0 ?
                               (RECOVER_NS + CLK_NS - 1) / CLK_NS : 1;
  localparam int RS_R_CYC    = (RS_TO_R_NS + CLK_NS - 1) / CLK_NS > 0 ?
                               (RS_TO_R_NS + CLK_NS - 1) / CLK_NS : 1;
  localparam int R_LOAD_CYC  = (R_TO_LOAD_NS + CLK_NS - 1) / CLK_NS > 0 ?
                               (R_TO_LOAD_NS + CLK_NS - 1) / CLK_NS : 1;
  localparam int ACCESS_CYC  = (ACCESS_NS + CLK_NS - 1) / CLK_NS > 0 ?
                               (ACCESS_NS + CLK_NS - 1) / CLK_NS : 1;
  // read data and flags only count once they have crossed the synchroniser
  localparam int READ_CYC    = ACCESS_CYC + SYNC_STAGES;
  localparam int SETTLE_CYC  = RECOVER_CYC + SYNC_STAGES;
  localparam int CNT_W       = 4;

  // word and threshold layout
  localparam int WORD_W       = 9;
  localparam int OFF_LSB      = 0;
  localparam int OFF_MSB      = 5;
  localparam int THR_CFG_BIT  = 8;
  localparam logic [5:0] OFF_MIN = 6'h01;

  // register map of the controller
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [7:0] REG_CMD    = 8'h00;
  localparam logic [7:0] REG_WDATA  = 8'h04;
  localparam logic [7:0] REG_AF_THR = 8'h08;
  localparam logic [7:0] REG_AE_THR = 8'h0c;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam logic [7:0] REG_RDATA  = 8'h14;
  localparam logic [7:0] REG_CFG    = 8'h18;
  // command bits
  localparam int CMD_RESET  = 0;
  localparam int CMD_LOAD   = 1;
  localparam int CMD_READ   = 2;
  localparam int CMD_REPLAY = 3;
  localparam int CMD_CLEAR  = 4;
  // configuration bits
  localparam int CFG_LOAD_VIA_Q = 0;
  localparam int CFG_CASCADE    = 1;
  // status bits, and the valid bit of the read data register
  localparam int ST_BUSY    = 0;
  localparam int ST_REFUSED = 1;
  localparam int ST_LOCKED  = 2;
  localparam int ST_FLAGS   = 3;
  localparam int RD_VALID   = 9;

  typedef struct packed {
    logic empty_n;
    logic full_n;
    logic third_n;
    logic almost_full_n;
    logic almost_empty_n;
  } afc_flags_s;

  typedef enum logic [3:0] {
    S_IDLE     = 4'h0,
    S_RST      = 4'h1,
    S_LD_R     = 4'h2,
    S_LD_WLOW  = 4'h3,
    S_LD_WREC  = 4'h4,
    S_LD_END   = 4'h5,
    S_WR_LOW   = 4'h6,
    S_RD_LOW   = 4'h7,
    S_RT_LOW   = 4'h8,
    S_REC      = 4'h9
  } afc_state_e;
endpackage

/* afc_sync.sv */
// two-stage synchroniser for pin inputs
`timescale 1ns/1ns
`default_nettype none
module afc_sync #(
  parameter int WIDTH  = 14,
  parameter int STAGES = 2
) (
  input  wire logic             CLK_SYS_I,
  input  wire logic             RESETN_I,
  input  wire logic [WIDTH-1:0] async_i,
  output var  logic [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] stage [STAGES];

  if (STAGES < 2) begin : g_chk
    $error("afc_sync needs at least two stages");
  end

  always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      for (int i = 0; i < STAGES; i++) begin
        stage[i] <= '1;
      end
    end else begin
      stage[0] <= async_i;
      for (int i = 1; i < STAGES; i++) begin
        stage[i] <= stage[i-1];
      end
    end
  end

  assign sync_o = stage[STAGES-1];
endmodule // afc_sync
`default_nettype wire

/* afc_host_ctrl.sv */
// host controller driving the strobe fifo pins from a register port
`timescale 1ns/1ns
`default_nettype none
module afc_host_ctrl #(
  parameter int WORD_W = afc_pkg::WORD_W
) (
  input  wire logic                       CLK_SYS_I,
  input  wire logic                       RESETN_I,
  input  wire logic [afc_pkg::ADDR_W-1:0] REG_ADDR_I,
  input  wire logic [afc_pkg::DATA_W-1:0] REG_WDATA_I,
  input  wire logic                       REG_WR_I,
  input  wire logic                       REG_RD_I,
  output var  logic [afc_pkg::DATA_W-1:0] REG_RDATA_O,
  output var  logic                       RESET_LINE_N_O,
  output var  logic                       READ_STROBE_N_O,
  output var  logic                       WRITE_STROBE_N_O,
  output var  logic                       REPLAY_N_O,
  output var  logic [WORD_W-1:0]          DATA_IN_PINS_O,
  input  wire logic [WORD_W-1:0]          DATA_OUT_PINS_I,
  output var  logic [WORD_W-1:0]          DATA_OUT_PINS_O,
  output var  logic                       DATA_OUT_PINS_OE_O,
  input  wire logic                       EMPTY_FLAG_N_I,
  input  wire logic                       FULL_FLAG_N_I,
  input  wire logic                       HALF_FULL_FLAG_N_I,
  input  wire logic                       ALMOST_FULL_FLAG_N_I,
  input  wire logic                       ALMOST_EMPTY_FLAG_N_I
);
  localparam int SYNC_W = WORD_W + 5;

  if (WORD_W != afc_pkg::WORD_W) begin : g_chk
    $error("afc_host_ctrl serves one 9-bit device word");
  end

  // pins cross into the clock domain before anything looks at them
  logic [SYNC_W-1:0]   sync_in;
  logic [SYNC_W-1:0]   sync_out;
  afc_pkg::afc_flags_s flags;
  logic [WORD_W-1:0]   q_sync;

  assign sync_in = {DATA_OUT_PINS_I, EMPTY_FLAG_N_I, FULL_FLAG_N_I, HALF_FULL_FLAG_N_I,
                    ALMOST_FULL_FLAG_N_I, ALMOST_EMPTY_FLAG_N_I};

  afc_sync #(
    .WIDTH  (SYNC_W),
    .STAGES (afc_pkg::SYNC_STAGES)
  ) u_sync (
    .CLK_SYS_I (CLK_SYS_I),
    .RESETN_I  (RESETN_I),
    .async_i   (sync_in),
    .sync_o    (sync_out)
  );

  assign flags  = afc_pkg::afc_flags_s'(sync_out[4:0]);
  assign q_sync = sync_out[SYNC_W-1:5];

  // threshold word as sent: offset clamped, reserved bits zero
  function automatic logic [WORD_W-1:0] thr_word(input logic [WORD_W-1:0] v);
    logic [WORD_W-1:0] w;
    w = '0;
    w[afc_pkg::OFF_MSB:afc_pkg::OFF_LSB] = v[afc_pkg::OFF_MSB:afc_pkg::OFF_LSB];
    if (v[afc_pkg::OFF_MSB:afc_pkg::OFF_LSB] < afc_pkg::OFF_MIN) begin
      w[afc_pkg::OFF_MSB:afc_pkg::OFF_LSB] = afc_pkg::OFF_MIN;
    end
    w[afc_pkg::THR_CFG_BIT] = v[afc_pkg::THR_CFG_BIT];
    return w;
  endfunction

  // controller state
  afc_pkg::afc_state_e      state, next_state;
  logic [afc_pkg::CNT_W-1:0] cnt, next_cnt;
  logic                      ld_idx, next_ld_idx;
  logic [WORD_W-1:0]         af_thr, next_af_thr;
  logic [WORD_W-1:0]         ae_thr, next_ae_thr;
  logic [WORD_W-1:0]         wdata, next_wdata;
  logic [WORD_W-1:0]         rdata, next_rdata;
  logic                      rvalid, next_rvalid;
  logic [1:0]                cfg, next_cfg;
  logic                      locked, next_locked;
  logic                      refused, next_refused;
  logic                      rs_n, next_rs_n;
  logic                      r_n, next_r_n;
  logic                      w_n, next_w_n;
  logic                      rt_n, next_rt_n;
  logic [WORD_W-1:0]         din, next_din;
  logic                      q_oe, next_q_oe;
  logic [afc_pkg::DATA_W-1:0] rd_q, next_rd_q;
  logic                      wr_cmd_pending, next_pending;

  logic wr_cmd, wr_wdata, busy, refuse;
  logic [afc_pkg::DATA_W-1:0] cmd;
  logic [WORD_W-1:0] ld_word;

  assign cmd      = REG_WDATA_I;
  assign wr_cmd   = REG_WR_I && (REG_ADDR_I == afc_pkg::REG_CMD);
  assign wr_wdata = REG_WR_I && (REG_ADDR_I == afc_pkg::REG_WDATA);
  assign busy     = (state != afc_pkg::S_IDLE);
  assign ld_word  = ld_idx ? thr_word(ae_thr) : thr_word(af_thr);

  always_comb begin
    next_state   = state;
    next_cnt     = (cnt != '0) ? cnt - 1'b1 : cnt;
    next_ld_idx  = ld_idx;
    next_af_thr  = af_thr;
    next_ae_thr  = ae_thr;
    next_wdata   = wdata;
    next_rdata   = rdata;
    next_rvalid  = rvalid;
    next_cfg     = cfg;
    next_locked  = locked;
    next_rs_n    = rs_n;
    next_r_n     = r_n;
    next_w_n     = w_n;
    next_rt_n    = rt_n;
    next_din     = din;
    next_q_oe    = q_oe;
    refuse       = 1'b0;
    // register writes
    if (REG_WR_I && REG_ADDR_I == afc_pkg::REG_AF_THR) begin
      next_af_thr = REG_WDATA_I[WORD_W-1:0];
    end
    if (REG_WR_I && REG_ADDR_I == afc_pkg::REG_AE_THR) begin
      next_ae_thr = REG_WDATA_I[WORD_W-1:0];
    end
    if (REG_WR_I && REG_ADDR_I == afc_pkg::REG_CFG) begin
      next_cfg = REG_WDATA_I[1:0];
    end
    case (state)
      afc_pkg::S_IDLE: begin
        if (wr_wdata) begin
          if (!flags.full_n) begin
            refuse = 1'b1;
          end else begin
            next_wdata = REG_WDATA_I[WORD_W-1:0];
            next_din   = REG_WDATA_I[WORD_W-1:0];
            next_w_n   = 1'b0;
            next_cnt   = afc_pkg::CNT_W'(afc_pkg::PULSE_CYC);
            next_state = afc_pkg::S_WR_LOW;
          end
        end else if (wr_cmd && cmd[afc_pkg::CMD_LOAD]) begin
          next_rs_n   = 1'b0;
          next_ld_idx = 1'b0;
          next_cnt    = afc_pkg::CNT_W'(afc_pkg::RS_R_CYC);
          next_state  = afc_pkg::S_RST;
        end else if (wr_cmd && cmd[afc_pkg::CMD_RESET]) begin
          if (locked) begin
            refuse = 1'b1;
          end else begin
            next_rs_n  = 1'b0;
            next_cnt   = afc_pkg::CNT_W'(afc_pkg::PULSE_CYC);
            next_state = afc_pkg::S_RST;
          end
        end else if (wr_cmd && cmd[afc_pkg::CMD_READ]) begin
          if (!flags.empty_n) begin
            refuse = 1'b1;
          end else begin
            next_r_n   = 1'b0;
            next_cnt   = afc_pkg::CNT_W'(afc_pkg::READ_CYC);
            next_state = afc_pkg::S_RD_LOW;
          end
        end else if (wr_cmd && cmd[afc_pkg::CMD_REPLAY]) begin
          if (cfg[afc_pkg::CFG_CASCADE]) begin
            refuse = 1'b1;
          end else begin
            next_rt_n  = 1'b0;
            next_cnt   = afc_pkg::CNT_W'(afc_pkg::PULSE_CYC);
            next_state = afc_pkg::S_RT_LOW;
          end
        end
      end
      afc_pkg::S_RST: begin
        if (cnt == '0) begin
          if (ld_idx == 1'b0 && !wr_cmd_pending) begin
            next_rs_n  = 1'b1;
            next_cnt   = afc_pkg::CNT_W'(afc_pkg::SETTLE_CYC);
            next_state = afc_pkg::S_REC;
          end else begin
            next_r_n  = 1'b0;
            next_rt_n = cfg[afc_pkg::CFG_LOAD_VIA_Q];
            next_cnt  = afc_pkg::CNT_W'(afc_pkg::R_LOAD_CYC);
            next_state = afc_pkg::S_LD_R;
          end
        end
      end
      afc_pkg::S_LD_R: begin
        if (cnt == '0) begin
          next_din   = ld_word;
          next_q_oe  = cfg[afc_pkg::CFG_LOAD_VIA_Q];
          next_w_n   = 1'b0;
          next_cnt   = afc_pkg::CNT_W'(afc_pkg::PULSE_CYC);
          next_state = afc_pkg::S_LD_WLOW;
        end
      end
      afc_pkg::S_LD_WLOW: begin
        if (cnt == '0) begin
          next_w_n   = 1'b1;
          next_cnt   = afc_pkg::CNT_W'(afc_pkg::RECOVER_CYC);
          next_state = afc_pkg::S_LD_WREC;
        end
      end
      afc_pkg::S_LD_WREC: begin
        if (cnt == '0) begin
          if (!ld_idx) begin
            next_ld_idx = 1'b1;
            next_din    = thr_word(ae_thr);
            next_w_n    = 1'b0;
            next_cnt    = afc_pkg::CNT_W'(afc_pkg::PULSE_CYC);
            next_state  = afc_pkg::S_LD_WLOW;
          end else begin
            next_q_oe   = 1'b0;
            next_r_n    = 1'b1;
            next_rt_n   = 1'b1;
            next_locked = ae_thr[afc_pkg::THR_CFG_BIT];
            next_state  = afc_pkg::S_LD_END;
          end
        end
      end
      afc_pkg::S_LD_END: begin
        next_rs_n   = 1'b1;
        next_ld_idx = 1'b0;
        next_cnt    = afc_pkg::CNT_W'(afc_pkg::SETTLE_CYC);
        next_state  = afc_pkg::S_REC;
      end
      afc_pkg::S_WR_LOW: begin
        if (cnt == '0) begin
          next_w_n   = 1'b1;
          next_cnt   = afc_pkg::CNT_W'(afc_pkg::SETTLE_CYC);
          next_state = afc_pkg::S_REC;
        end
      end
      afc_pkg::S_RD_LOW: begin
        if (cnt == '0) begin
          next_rdata  = q_sync;
          next_rvalid = 1'b1;
          next_r_n    = 1'b1;
          next_cnt    = afc_pkg::CNT_W'(afc_pkg::SETTLE_CYC);
          next_state  = afc_pkg::S_REC;
        end
      end
      afc_pkg::S_RT_LOW: begin
        if (cnt == '0) begin
          next_rt_n  = 1'b1;
          next_cnt   = afc_pkg::CNT_W'(afc_pkg::SETTLE_CYC);
          next_state = afc_pkg::S_REC;
        end
      end
      afc_pkg::S_REC: begin
        if (cnt == '0) begin
          next_state = afc_pkg::S_IDLE;
        end
      end
      default: begin
        next_state = afc_pkg::S_IDLE;
      end
    endcase
    // a command other than clear, or a data write, while busy is refused, not queued
    if (busy && (wr_wdata || (wr_cmd && cmd[3:0] != 4'h0))) begin
      refuse = 1'b1;
    end
    if (REG_RD_I && REG_ADDR_I == afc_pkg::REG_RDATA) begin
      next_rvalid = 1'b0;
    end
  end

  // load entry marks itself through ld_idx staying clear and a pending flag
  always_comb begin
    next_pending = wr_cmd_pending;
    if (state == afc_pkg::S_IDLE && wr_cmd && cmd[afc_pkg::CMD_LOAD] && !wr_wdata) begin
      next_pending = 1'b1;
    end else if (state == afc_pkg::S_LD_END) begin
      next_pending = 1'b0;
    end
  end

  // refusal is sticky; a new refusal wins over a clear in the same cycle
  always_comb begin
    next_refused = refused;
    if (wr_cmd && cmd[afc_pkg::CMD_CLEAR]) begin
      next_refused = 1'b0;
    end
    if (refuse) begin
      next_refused = 1'b1;
    end
  end

  always_comb begin
    next_rd_q = '0;
    if (REG_RD_I) begin
      case (REG_ADDR_I)
        afc_pkg::REG_AF_THR: next_rd_q[WORD_W-1:0] = af_thr;
        afc_pkg::REG_AE_THR: next_rd_q[WORD_W-1:0] = ae_thr;
        afc_pkg::REG_WDATA:  next_rd_q[WORD_W-1:0] = wdata;
        afc_pkg::REG_CFG:    next_rd_q[1:0] = cfg;
        afc_pkg::REG_RDATA: begin
          next_rd_q[WORD_W-1:0]       = rdata;
          next_rd_q[afc_pkg::RD_VALID] = rvalid;
        end
        afc_pkg::REG_STATUS: begin
          next_rd_q[afc_pkg::ST_BUSY]    = busy;
          next_rd_q[afc_pkg::ST_REFUSED] = refused;
          next_rd_q[afc_pkg::ST_LOCKED]  = locked;
          next_rd_q[afc_pkg::ST_FLAGS +: 5] = flags;
        end
        default: next_rd_q = '0;
      endcase
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      state          <= afc_pkg::S_IDLE;
      cnt            <= '0;
      ld_idx         <= 1'b0;
      wr_cmd_pending <= 1'b0;
      af_thr         <= '0;
      ae_thr         <= '0;
      wdata          <= '0;
      rdata          <= '0;
      rvalid         <= 1'b0;
      cfg            <= '0;
      locked         <= 1'b0;
      refused        <= 1'b0;
      rs_n           <= 1'b1;
      r_n            <= 1'b1;
      w_n            <= 1'b1;
      rt_n           <= 1'b1;
      din            <= '0;
      q_oe           <= 1'b0;
      rd_q           <= '0;
    end else begin
      state          <= next_state;
      cnt            <= next_cnt;
      ld_idx         <= next_ld_idx;
      wr_cmd_pending <= next_pending;
      af_thr         <= next_af_thr;
      ae_thr         <= next_ae_thr;
      wdata          <= next_wdata;
      rdata          <= next_rdata;
      rvalid         <= next_rvalid;
      cfg            <= next_cfg;
      locked         <= next_locked;
      refused        <= next_refused;
      rs_n           <= next_rs_n;
      r_n            <= next_r_n;
      w_n            <= next_w_n;
      rt_n           <= next_rt_n;
      din            <= next_din;
      q_oe           <= next_q_oe;
      rd_q           <= next_rd_q;
    end
  end

  assign REG_RDATA_O        = rd_q;
  assign RESET_LINE_N_O     = rs_n;
  assign READ_STROBE_N_O    = r_n;
  assign WRITE_STROBE_N_O   = w_n;
  assign REPLAY_N_O         = rt_n;
  assign DATA_IN_PINS_O     = din;
  assign DATA_OUT_PINS_O    = din;
  assign DATA_OUT_PINS_OE_O = q_oe;
endmodule // afc_host_ctrl
`default_nettype wire

/* afc_host_ctrl_monitor.sv */
// pin timing checker for the fifo host controller
`timescale 1ns/1ns
`default_nettype none
module afc_host_ctrl_monitor #(
  parameter int WORD_W = afc_pkg::WORD_W
) (
  input wire logic              CLK_SYS_I,
  input wire logic              RESETN_I,
  input wire logic              RESET_LINE_N_O,
  input wire logic              READ_STROBE_N_O,
  input wire logic              WRITE_STROBE_N_O,
  input wire logic              REPLAY_N_O,
  input wire logic [WORD_W-1:0] DATA_IN_PINS_O,
  input wire logic [WORD_W-1:0] DATA_OUT_PINS_O,
  input wire logic              DATA_OUT_PINS_OE_O
);
  default clocking @(posedge CLK_SYS_I); endclocking
  default disable iff (!RESETN_I);
  a_reset_strobes_high : assert property (
    $fell(RESET_LINE_N_O) |-> READ_STROBE_N_O && WRITE_STROBE_N_O)
    else $error("reset line fell with a strobe low");
  a_load_read_gap : assert property (
    $fell(READ_STROBE_N_O) && !RESET_LINE_N_O |-> !$past(RESET_LINE_N_O, 2))
    else $error("load read strobe too soon after reset line");
  a_load_end_order : assert property (
    $rose(RESET_LINE_N_O) |-> $past(READ_STROBE_N_O) && WRITE_STROBE_N_O)
    else $error("reset line released before read strobe");
  a_load_data_stable : assert property (
    !WRITE_STROBE_N_O && !$past(WRITE_STROBE_N_O)
      |-> $stable(DATA_IN_PINS_O) && $stable(DATA_OUT_PINS_O))
    else $error("data moved while write strobe low");
  a_write_pulse_len : assert property (
    $fell(WRITE_STROBE_N_O) && RESET_LINE_N_O |=> !WRITE_STROBE_N_O ##1 WRITE_STROBE_N_O)
    else $error("write pulse length wrong");
  a_read_pulse_len : assert property (
    $fell(READ_STROBE_N_O) && RESET_LINE_N_O |=> !READ_STROBE_N_O [*3] ##1 READ_STROBE_N_O)
    else $error("read pulse length wrong");
  a_q_drive_load : assert property (
    DATA_OUT_PINS_OE_O |-> !RESET_LINE_N_O && REPLAY_N_O)
    else $error("output pins driven outside load via output pins");
  a_no_dual_strobe : assert property (
    RESET_LINE_N_O |-> READ_STROBE_N_O || WRITE_STROBE_N_O)
    else $error("both strobes low in normal operation");
  a_replay_pulse_len : assert property (
    $fell(REPLAY_N_O) && RESET_LINE_N_O |=> !REPLAY_N_O ##1 REPLAY_N_O)
    else $error("replay pulse length wrong");
endmodule // afc_host_ctrl_monitor

bind afc_host_ctrl afc_host_ctrl_monitor #(.WORD_W(WORD_W)) i_afc_host_ctrl_monitor (
  .CLK_SYS_I(CLK_SYS_I), .RESETN_I(RESETN_I), .RESET_LINE_N_O(RESET_LINE_N_O),
  .READ_STROBE_N_O(READ_STROBE_N_O), .WRITE_STROBE_N_O(WRITE_STROBE_N_O),
  .REPLAY_N_O(REPLAY_N_O), .DATA_IN_PINS_O(DATA_IN_PINS_O),
  .DATA_OUT_PINS_O(DATA_OUT_PINS_O), .DATA_OUT_PINS_OE_O(DATA_OUT_PINS_OE_O));
`default_nettype wire

/* afc_fifo_model.sv */
// behavioural strobe fifo device, standalone mode only
`timescale 1ns/1ns
`default_nettype none
module afc_fifo_model #(
  parameter int DEPTH = 16
) (
  input  wire logic       reset_line_n_i,
  input  wire logic       read_n_i,
  input  wire logic       write_n_i,
  input  wire logic       replay_n_i,
  input  wire logic [8:0] data_in_pins_i,
  input  wire logic [8:0] q_i,
  output logic      [8:0] q_o,
  output logic            q_oe_o,
  output logic      [4:0] flags_n_o
);
  logic [8:0] mem [DEPTH];
  logic [8:0] af_thr = 9'h000;
  logic [8:0] ae_thr = 9'h000;
  logic       loading = 1'b0;
  logic       locked = 1'b0;
  int         wp = 0;
  int         rp = 0;
  int         cnt = 0;
  int         ld = 0;
  initial q_o = 9'h000;
  initial q_oe_o = 1'b0;
  // flag order matches the controller status field
  assign flags_n_o[4] = cnt != 0;
  assign flags_n_o[3] = cnt != DEPTH;
  assign flags_n_o[2] = af_thr[8] ? (cnt != 0 && cnt != DEPTH) : !(cnt > DEPTH / 2);
  assign flags_n_o[1] = (DEPTH - cnt) >= 2 * af_thr[5:0];
  assign flags_n_o[0] = cnt >= 2 * ae_thr[5:0];
  always @(negedge reset_line_n_i) if (!locked) begin
    wp = 0;
    rp = 0;
    cnt = 0;
  end
  always @(posedge reset_line_n_i) if (loading) begin
    loading = 1'b0;
    locked = ae_thr[8];
  end
  always @(negedge read_n_i) if (!reset_line_n_i) begin
    loading = 1'b1;
    ld = 0;
  end else if (cnt > 0) begin
    q_o = mem[rp];
    q_oe_o = 1'b1;
    rp = (rp + 1) % DEPTH;
    cnt--;
  end
  // output released at strobe end, the bench then shows junk on the wire
  always @(posedge read_n_i) q_oe_o = 1'b0;
  always @(posedge write_n_i) if (loading) begin
    if (ld == 0) af_thr = replay_n_i ? q_i : data_in_pins_i;
    else ae_thr = replay_n_i ? q_i : data_in_pins_i;
    ld++;
  end else if (reset_line_n_i && cnt < DEPTH) begin
    mem[wp] = data_in_pins_i;
    wp = (wp + 1) % DEPTH;
    cnt++;
  end
  // cascade token passing lies outside this single-device model
  // valid only while fewer than DEPTH writes since reset
  always @(negedge replay_n_i) if (reset_line_n_i) begin
    rp = 0;
    cnt = wp;
  end
endmodule // afc_fifo_model
`default_nettype wire

/* afc_host_ctrl_tb.sv */
// self-checking bench for the fifo host controller
`timescale 1ns/1ns
`default_nettype none
module afc_host_ctrl_tb;
  localparam int DEPTH = 16;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [31:0] rdata;
  logic [31:0] st;
  logic        line_n, r_n, w_n, replay_n, host_oe, dev_oe;
  logic [8:0]  d_pins, host_q, dev_q;
  logic [8:0]  q_last = 9'h000;
  logic [4:0]  flg_n;
  int          mismatches = 0;
  int          checks_done = 0;
  wire  [8:0]  q_wire = host_oe ? host_q : dev_oe ? dev_q : ~q_last;
  always #20 clk = ~clk;
  always @(posedge clk) if (host_oe || dev_oe) q_last <= q_wire;
  afc_host_ctrl i_afc_host_ctrl (.CLK_SYS_I(clk), .RESETN_I(rst_n), .REG_ADDR_I(addr),
    .REG_WDATA_I(wdata), .REG_WR_I(wr), .REG_RD_I(rd), .REG_RDATA_O(rdata),
    .RESET_LINE_N_O(line_n), .READ_STROBE_N_O(r_n), .WRITE_STROBE_N_O(w_n),
    .REPLAY_N_O(replay_n), .DATA_IN_PINS_O(d_pins), .DATA_OUT_PINS_I(q_wire),
    .DATA_OUT_PINS_O(host_q), .DATA_OUT_PINS_OE_O(host_oe), .EMPTY_FLAG_N_I(flg_n[4]),
    .FULL_FLAG_N_I(flg_n[3]), .HALF_FULL_FLAG_N_I(flg_n[2]),
    .ALMOST_FULL_FLAG_N_I(flg_n[1]), .ALMOST_EMPTY_FLAG_N_I(flg_n[0]));
  afc_fifo_model #(.DEPTH(DEPTH)) i_afc_fifo_model (.reset_line_n_i(line_n),
    .read_n_i(r_n), .write_n_i(w_n), .replay_n_i(replay_n), .data_in_pins_i(d_pins),
    .q_i(q_wire), .q_o(dev_q), .q_oe_o(dev_oe), .flags_n_o(flg_n));
  task automatic end_sim();
    if (mismatches == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic reg_rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask
  // poll busy; a hang counts as a mismatch
  task automatic idle();
    for (int i = 0; i < 40; i++) begin
      reg_rd(afc_pkg::REG_STATUS, st);
      if (st[afc_pkg::ST_BUSY] === 1'b0) return;
    end
    mismatches++;
    end_sim();
  endtask
  task automatic cmd(input int b);
    reg_wr(afc_pkg::REG_CMD, 32'h1 << b);
    idle();
  endtask
  task automatic stbit(input int b, input logic e);
    reg_rd(afc_pkg::REG_STATUS, st);
    chk("status bit", {31'h0, e}, {31'h0, st[b]});
  endtask
  task automatic load(input logic [8:0] af, input logic [8:0] ae);
    reg_wr(afc_pkg::REG_AF_THR, {23'h0, af});
    reg_wr(afc_pkg::REG_AE_THR, {23'h0, ae});
    cmd(afc_pkg::CMD_LOAD);
  endtask
  task automatic put(input logic [8:0] v);
    reg_wr(afc_pkg::REG_WDATA, {23'h0, v});
    idle();
  endtask
  task automatic get(input logic [8:0] v);
    cmd(afc_pkg::CMD_READ);
    reg_rd(afc_pkg::REG_RDATA, st);
    chk("read word", {22'h0, 1'b1, v}, {22'h0, st[9:0]});
  endtask
  // both thresholds carry offset 5, a distance of 10 words
  task automatic flags(input int c, input logic fe);
    logic e;
    logic f;
    e = c != 0;
    f = c != DEPTH;
    reg_rd(afc_pkg::REG_STATUS, st);
    chk("flags", {27'h0, e, f, fe ? (e && f) : (c <= DEPTH / 2), (DEPTH - c) >= 10, c >= 10},
      {27'h0, st[afc_pkg::ST_FLAGS +: 5]});
  endtask
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    reg_rd(8'h1c, st);
    chk("unmapped", 32'h0, st);
    load(9'h105, 9'h0c5);
    chk("af reg", 32'h105, {23'h0, i_afc_fifo_model.af_thr});
    chk("ae reg", 32'h005, {23'h0, i_afc_fifo_model.ae_thr});
    for (int n = 1; n <= DEPTH; n++) begin
      put(9'(n * 37));
      flags(n, 1'b1);
    end
    put(9'h1ff);
    stbit(afc_pkg::ST_REFUSED, 1'b1);
    cmd(afc_pkg::CMD_CLEAR);
    stbit(afc_pkg::ST_REFUSED, 1'b0);
    for (int n = 1; n <= DEPTH; n++) begin
      get(9'(n * 37));
      flags(DEPTH - n, 1'b1);
    end
    cmd(afc_pkg::CMD_READ);
    stbit(afc_pkg::ST_REFUSED, 1'b1);
    cmd(afc_pkg::CMD_CLEAR);
    reg_wr(afc_pkg::REG_CFG, 32'h1);
    load(9'h005, 9'h0c5);
    chk("af via q", 32'h005, {23'h0, i_afc_fifo_model.af_thr});
    reg_wr(afc_pkg::REG_CFG, 32'h0);
    for (int n = 1; n <= 9; n++) begin
      put(9'(n));
      flags(n, 1'b0);
    end
    get(9'h001);
    get(9'h002);
    cmd(afc_pkg::CMD_REPLAY);
    get(9'h001);
    // the locking load itself still resets, so refill before testing the lock
    load(9'h005, 9'h1c5);
    stbit(afc_pkg::ST_LOCKED, 1'b1);
    put(9'h00a);
    put(9'h00b);
    cmd(afc_pkg::CMD_RESET);
    stbit(afc_pkg::ST_REFUSED, 1'b1);
    load(9'h005, 9'h0c5);
    get(9'h00a);
    get(9'h00b);
    stbit(afc_pkg::ST_LOCKED, 1'b0);
    put(9'h00c);
    cmd(afc_pkg::CMD_RESET);
    flags(0, 1'b0);
    cmd(afc_pkg::CMD_CLEAR);
    reg_wr(afc_pkg::REG_CFG, 32'h2);
    cmd(afc_pkg::CMD_REPLAY);
    stbit(afc_pkg::ST_REFUSED, 1'b1);
    end_sim();
  end
endmodule // afc_host_ctrl_tb
`default_nettype wire
